/* shared/lft_pkg.sv */
// constants and types for the lcd frame timing and drive configuration block
package lft_pkg;

   localparam int unsigned LFT_CLK_HZ = 125000000;
   localparam int unsigned LFT_OSC_HZ = 230000;
   // rounded down so the internal tick is never slower than nominal
   localparam int unsigned LFT_OSC_DIV = LFT_CLK_HZ / LFT_OSC_HZ;
   localparam logic [9:0] LFT_OSC_LAST = 10'(LFT_OSC_DIV - 1);

   localparam logic [5:0] LFT_FRAME_TICKS = 6'h30;
   localparam logic [3:0] LFT_ROW_TICKS_8 = 4'h6;
   localparam logic [3:0] LFT_ROW_TICKS_6 = 4'h8;
   localparam logic [3:0] LFT_ROW_TICKS_4 = 4'hc;

   localparam logic [2:0] LFT_FF_PATTERN = 3'h1;
   localparam logic [5:0] LFT_MUX_PATTERN = 6'h00;
   localparam logic [5:0] LFT_BIAS_PATTERN = 6'h01;
   localparam logic [4:0] LFT_OSC_PATTERN = 5'h03;
   localparam int unsigned LFT_EFR_BIT = 2;
   localparam int unsigned LFT_COE_BIT = 1;
   localparam int unsigned LFT_SRC_BIT = 0;

   localparam logic [4:0] LFT_FD_RESET = 5'h0e;
   localparam logic [4:0] LFT_FD_LAST = 5'h16;
   localparam logic [6:0] LFT_Q_RESET = 7'h18;
   localparam logic [1:0] LFT_MUX_RESET = 2'h0;
   localparam logic [1:0] LFT_BIAS_RESET = 2'h0;

   typedef logic [6:0] lft_q_t;
   localparam lft_q_t LFT_Q_TABLE [0:22] = '{
      7'h50, 7'h44, 7'h3c, 7'h35, 7'h30, 7'h2c, 7'h28, 7'h25, 7'h22, 7'h20, 7'h1e, 7'h1c,
      7'h1b, 7'h19, 7'h18, 7'h17, 7'h16, 7'h15, 7'h14, 7'h13, 7'h12, 7'h11, 7'h10};

   typedef enum logic [1:0] {
      LFT_BIAS_QUARTER,
      LFT_BIAS_THIRD,
      LFT_BIAS_HALF
   } lft_bias_e;

   typedef struct packed {
      logic ext_fast;
      logic clk_out_en;
      logic ext_src;
      logic [1:0] mux_sel;
      logic [1:0] bias_sel;
      logic [4:0] fd_code;
      lft_q_t q;
   } lft_cfg_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } lft_cmd_s;

   typedef struct packed {
      logic out;
      logic oe;
   } lft_pin_s;

endpackage

/* logic/lft_top.sv */
// lcd frame timing, clock pin control and drive configuration
`timescale 1ns/1ps
`default_nettype none
module lft_top
   import lft_pkg::*;
(
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CMD_VALID_I,
   input wire logic [7:0] CMD_BYTE_I,
   input wire logic POWER_DOWN_BIT_I,
   input wire logic CLOCK_IO_PIN_I,
   output logic CLOCK_IO_PIN_O,
   output logic CLOCK_IO_PIN_OE_O,
   output logic FRAME_O,
   output logic ROW_LOAD_O,
   output logic [2:0] BACKPLANE_O,
   output logic [3:0] BACKPLANES_O,
   output logic [1:0] BIAS_O,
   output logic EXTERNAL_FREQ_RANGE_O,
   output logic CLOCK_OUTPUT_ENABLE_O,
   output logic CLOCK_SOURCE_EXT_O,
   output logic [4:0] FRAME_DIVIDER_CODE_O,
   output logic [6:0] DIVIDE_FACTOR_O
);

   typedef struct packed {
      lft_cfg_s cfg;
      lft_pin_s pin;
      logic [2:0] sync;
      logic [9:0] osc_cnt;
      logic [6:0] q_cnt;
      logic [5:0] frame_cnt;
      logic [3:0] row_cnt;
      logic [2:0] row;
      logic frame;
      logic row_load;
   } lft_state_s;

   lft_state_s st_reg;
   lft_state_s st_next;
   lft_cmd_s cmd;

   assign cmd = '{valid: CMD_VALID_I, data: CMD_BYTE_I};

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic lft_bias_e bias_of(input logic [1:0] sel);
      bias_of = LFT_BIAS_QUARTER;
      unique case (sel)
         2'h0, 2'h1: bias_of = LFT_BIAS_QUARTER;
         2'h2: bias_of = LFT_BIAS_HALF;
         2'h3: bias_of = LFT_BIAS_THIRD;
      endcase
   endfunction

   function automatic logic [3:0] row_ticks_of(input logic [1:0] sel);
      row_ticks_of = LFT_ROW_TICKS_8;
      unique case (sel)
         2'h0, 2'h1: row_ticks_of = LFT_ROW_TICKS_8;
         2'h2: row_ticks_of = LFT_ROW_TICKS_6;
         2'h3: row_ticks_of = LFT_ROW_TICKS_4;
      endcase
   endfunction

   function automatic logic [3:0] planes_of(input logic [1:0] sel);
      planes_of = 4'h8;
      unique case (sel)
         2'h0, 2'h1: planes_of = 4'h8;
         2'h2: planes_of = 4'h6;
         2'h3: planes_of = 4'h4;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic osc_tick;
      logic ext_rise;
      logic base_tick;
      logic lcd_tick;
      logic [3:0] row_ticks;
      logic mux_cmd;
      st_next = st_reg;
      osc_tick = 1'b0;
      ext_rise = 1'b0;
      base_tick = 1'b0;
      lcd_tick = 1'b0;
      mux_cmd = 1'b0;
      row_ticks = row_ticks_of(st_reg.cfg.mux_sel);
      st_next.frame = 1'b0;
      st_next.row_load = 1'b0;

      // command bytes; fixed upper bits select the target
      if (cmd.valid) begin
         if (cmd.data[7:5] == LFT_FF_PATTERN) begin
            if (cmd.data[4:0] <= LFT_FD_LAST) begin
               st_next.cfg.fd_code = cmd.data[4:0];
               st_next.cfg.q = LFT_Q_TABLE[cmd.data[4:0]];
            end
         end else if (cmd.data[7:2] == LFT_MUX_PATTERN) begin
            st_next.cfg.mux_sel = cmd.data[1:0];
            mux_cmd = 1'b1;
         end else if (cmd.data[7:2] == LFT_BIAS_PATTERN) begin
            st_next.cfg.bias_sel = cmd.data[1:0];
         end else if (cmd.data[7:3] == LFT_OSC_PATTERN) begin
            st_next.cfg.ext_fast = cmd.data[LFT_EFR_BIT];
            st_next.cfg.clk_out_en = cmd.data[LFT_COE_BIT];
            st_next.cfg.ext_src = cmd.data[LFT_SRC_BIT];
         end
      end

      // pin synchroniser; only stages two and three feed the edge detector
      st_next.sync = {st_reg.sync[1:0], CLOCK_IO_PIN_I};
      ext_rise = st_reg.sync[1] & ~st_reg.sync[2];

      // internal oscillator stops in power-down to save current
      if (POWER_DOWN_BIT_I || st_reg.cfg.ext_src) begin
         st_next.osc_cnt = '0;
      end else if (st_reg.osc_cnt >= LFT_OSC_LAST) begin
         st_next.osc_cnt = '0;
         osc_tick = 1'b1;
      end else begin
         st_next.osc_cnt = st_reg.osc_cnt + 10'h001;
      end

      base_tick = st_reg.cfg.ext_src ? ext_rise : osc_tick;

      // prescaler by q, bypassed for the slow external clock
      if (st_reg.cfg.ext_src && !st_reg.cfg.ext_fast) begin
         lcd_tick = base_tick;
         st_next.q_cnt = '0;
      end else if (base_tick) begin
         if (st_reg.q_cnt >= st_reg.cfg.q - 7'h01) begin
            st_next.q_cnt = '0;
            lcd_tick = 1'b1;
         end else begin
            st_next.q_cnt = st_reg.q_cnt + 7'h01;
         end
      end

      // 48 lcd ticks to the frame, split evenly over the backplanes
      if (lcd_tick) begin
         if (st_reg.frame_cnt >= LFT_FRAME_TICKS - 6'h01) begin
            st_next.frame_cnt = '0;
            st_next.row_cnt = '0;
            st_next.row = '0;
            st_next.frame = 1'b1;
            st_next.row_load = 1'b1;
         end else begin
            st_next.frame_cnt = st_reg.frame_cnt + 6'h01;
            if (st_reg.row_cnt >= row_ticks - 4'h1) begin
               st_next.row_cnt = '0;
               st_next.row = st_reg.row + 3'h1;
               st_next.row_load = 1'b1;
            end else begin
               st_next.row_cnt = st_reg.row_cnt + 4'h1;
            end
         end
      end

      // a new plane count restarts the frame;
      // one short frame is cheaper than showing
      // a backplane index the new mode lacks
      if (mux_cmd) begin
         st_next.frame_cnt = '0;
         st_next.row_cnt = '0;
         st_next.row = '0;
         st_next.row_load = 1'b1;
      end

      // clock pin; an external source keeps it an input, power-down included
      // duty cycle of the intermediate clock varies with q
      if (st_reg.cfg.ext_src) begin
         st_next.pin.oe = 1'b0;
         st_next.pin.out = 1'b0;
      end else if (POWER_DOWN_BIT_I) begin
         st_next.pin.oe = st_reg.cfg.clk_out_en;
         st_next.pin.out = 1'b1;
      end else begin
         st_next.pin.oe = st_reg.cfg.clk_out_en;
         st_next.pin.out = st_reg.q_cnt < {1'b0, st_reg.cfg.q[6:1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         st_reg <= '0;
         st_reg.cfg.fd_code <= LFT_FD_RESET;
         st_reg.cfg.q <= LFT_Q_RESET;
         st_reg.cfg.mux_sel <= LFT_MUX_RESET;
         st_reg.cfg.bias_sel <= LFT_BIAS_RESET;
         st_reg.pin.oe <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign CLOCK_IO_PIN_O = st_reg.pin.out;
   assign CLOCK_IO_PIN_OE_O = st_reg.pin.oe;
   assign FRAME_O = st_reg.frame;
   assign ROW_LOAD_O = st_reg.row_load;
   assign BACKPLANE_O = st_reg.row;
   assign BACKPLANES_O = planes_of(st_reg.cfg.mux_sel);
   assign BIAS_O = bias_of(st_reg.cfg.bias_sel);
   assign EXTERNAL_FREQ_RANGE_O = st_reg.cfg.ext_fast;
   assign CLOCK_OUTPUT_ENABLE_O = st_reg.cfg.clk_out_en;
   assign CLOCK_SOURCE_EXT_O = st_reg.cfg.ext_src;
   assign FRAME_DIVIDER_CODE_O = st_reg.cfg.fd_code;
   assign DIVIDE_FACTOR_O = st_reg.cfg.q;

endmodule
`default_nettype wire

/* sim/lft_chk_assertions.sv */
// port assertions for the lcd frame timing block
`timescale 1ns/1ps
`default_nettype none
module lft_chk
   import lft_pkg::*;
(
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CMD_VALID_I,
   input wire logic [7:0] CMD_BYTE_I,
   input wire logic POWER_DOWN_BIT_I,
   input wire logic CLOCK_IO_PIN_O,
   input wire logic CLOCK_IO_PIN_OE_O,
   input wire logic FRAME_O,
   input wire logic ROW_LOAD_O,
   input wire logic [2:0] BACKPLANE_O,
   input wire logic [3:0] BACKPLANES_O,
   input wire logic [1:0] BIAS_O,
   input wire logic EXTERNAL_FREQ_RANGE_O,
   input wire logic CLOCK_OUTPUT_ENABLE_O,
   input wire logic CLOCK_SOURCE_EXT_O,
   input wire logic [4:0] FRAME_DIVIDER_CODE_O,
   input wire logic [6:0] DIVIDE_FACTOR_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   ////////////////////////////////////////////////////////////////////////////////
   a_fd_load:
      assert property (CMD_VALID_I && CMD_BYTE_I[7:5] == 3'h1 && CMD_BYTE_I[4:0] <= 5'h16
         |=> FRAME_DIVIDER_CODE_O == $past(CMD_BYTE_I[4:0])) else $error("code not taken");
   a_fd_unused:
      assert property (CMD_VALID_I && CMD_BYTE_I[7:5] == 3'h1 && CMD_BYTE_I[4:0] > 5'h16
         |=> $stable(DIVIDE_FACTOR_O)) else $error("unused code changed q");
   a_mux_sel:
      assert property (CMD_VALID_I && CMD_BYTE_I[7:2] == 6'h00 |=> BACKPLANES_O ==
         ($past(CMD_BYTE_I[1:0]) == 2'h3 ? 4'h4 : $past(CMD_BYTE_I[1:0]) == 2'h2 ? 4'h6 : 4'h8))
         else $error("bad plane count");
   a_bias_sel:
      assert property (CMD_VALID_I && CMD_BYTE_I[7:2] == 6'h01 |=> BIAS_O ==
         ($past(CMD_BYTE_I[1:0]) == 2'h3 ? 2'h1 : $past(CMD_BYTE_I[1:0]) == 2'h2 ? 2'h2 : 2'h0))
         else $error("bad bias");
   a_osc_bits:
      assert property (CMD_VALID_I && CMD_BYTE_I[7:3] == 5'h03 |=> {EXTERNAL_FREQ_RANGE_O,
         CLOCK_OUTPUT_ENABLE_O, CLOCK_SOURCE_EXT_O} == $past(CMD_BYTE_I[2:0]))
         else $error("osc bits not taken");
   a_frame_row:
      assert property (FRAME_O |-> ROW_LOAD_O && BACKPLANE_O == 3'h0)
         else $error("frame misaligned");
   a_ext_hiz:
      assert property (CLOCK_SOURCE_EXT_O |=> !CLOCK_IO_PIN_OE_O)
         else $error("pin driven as input");
   a_pd_drive:
      assert property (POWER_DOWN_BIT_I && CLOCK_OUTPUT_ENABLE_O && !CLOCK_SOURCE_EXT_O
         |=> CLOCK_IO_PIN_OE_O && CLOCK_IO_PIN_O) else $error("power-down pin not high");
   a_coe_off:
      assert property (!CLOCK_OUTPUT_ENABLE_O |=> !CLOCK_IO_PIN_OE_O) else $error("pin not off");
   a_row_range:
      assert property ({1'b0, BACKPLANE_O} < BACKPLANES_O) else $error("row past last plane");
endmodule
bind lft_top lft_chk lft_chk_inst (.*);
`default_nettype wire

/* sim/lft_ext_clk.sv */
// external clock source on the shared clock pin
`timescale 1ns/1ps
`default_nettype none
module lft_ext_clk (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic [7:0] half_i,
   output logic pin_o
);
   logic [7:0] cnt = 8'h00;
   logic lvl = 1'b0;
   assign pin_o = lvl;
   // released pin toggles each cycle so a floating level never looks steady
   always @(posedge clk_i) begin
      cnt <= (en_i && cnt != half_i - 8'h01) ? cnt + 8'h01 : 8'h00;
      if (!en_i || cnt == half_i - 8'h01) begin
         lvl <= ~lvl;
      end
   end
endmodule
`default_nettype wire

/* sim/lft_top_test.sv */
// self-checking bench for the frame timing block
`timescale 1ns/1ps
`default_nettype none
module lft_top_test;
   import lft_pkg::*;
   logic clk = 1'b0, rst = 1'b1, v = 1'b0, pd = 1'b0, en = 1'b0, pin;
   logic [7:0] b = 8'h00;
   logic po, poe, fr, rl, external_freq_range, clock_output_enable, src;
   logic [2:0] bp;
   logic [3:0] nbp;
   logic [1:0] bias;
   logic [4:0] fd;
   logic [6:0] q;
   int num_errors = 0, checked = 0;
   always #4 clk = ~clk;
   lft_ext_clk lft_ext_clk_inst (.clk_i(clk), .en_i(en), .half_i(8'h04), .pin_o(pin));
   lft_top lft_top_inst (.CLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(v), .CMD_BYTE_I(b),
      .POWER_DOWN_BIT_I(pd), .CLOCK_IO_PIN_I(pin), .CLOCK_IO_PIN_O(po), .CLOCK_IO_PIN_OE_O(poe),
      .FRAME_O(fr), .ROW_LOAD_O(rl), .BACKPLANE_O(bp), .BACKPLANES_O(nbp), .BIAS_O(bias),
      .EXTERNAL_FREQ_RANGE_O(external_freq_range), .CLOCK_OUTPUT_ENABLE_O(clock_output_enable), .CLOCK_SOURCE_EXT_O(src),
      .FRAME_DIVIDER_CODE_O(fd), .DIVIDE_FACTOR_O(q));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", s, e, g);
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      @(posedge clk);
      v <= 1'b1;
      b <= c;
      @(posedge clk);
      v <= 1'b0;
      #1;
   endtask
   // cycles until the next rise of the pin or of the frame pulse
   task automatic gap(input logic p, output int n);
      logic a, c;
      n = 0;
      a = 1'b1;
      while (n < 20000) begin
         @(posedge clk);
         #1;
         n++;
         c = p ? po : fr;
         if (c === 1'b1 && a === 1'b0) return;
         a = c;
      end
   endtask
   // row loads up to and including the next frame start, and the last index
   task automatic rows(output int r, output logic [2:0] m);
      r = 0;
      m = 3'h0;
      for (int k = 0; k < 20000; k++) begin
         @(posedge clk);
         #1;
         if (rl === 1'b1) begin
            r++;
         end
         if (fr === 1'b1) begin
            break;
         end
         m = bp;
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_fd;
      logic [4:0] c [4] = '{5'h00, 5'h0d, 5'h0e, 5'h16};
      int e [4] = '{80, 25, 24, 16};
      foreach (c[i]) begin
         cmd({3'h1, c[i]});
         chk("q", q, e[i]);
         chk("code", fd, c[i]);
      end
      cmd(8'h37);
      chk("q kept", q, 16);
      chk("code kept", fd, 5'h16);
      $display("t_fd done");
   endtask
   task automatic t_mb;
      int m [4] = '{8, 8, 6, 4};
      int s [4] = '{0, 0, 2, 1};
      for (int i = 0; i < 4; i++) begin
         cmd(8'(i));
         chk("planes", nbp, m[i]);
         cmd(8'h04 | 8'(i));
         chk("bias", bias, s[i]);
      end
      cmd(8'h00);
      $display("t_mb done");
   endtask
   task automatic t_pin;
      int n;
      cmd(8'h1a);
      gap(1'b1, n);
      gap(1'b1, n);
      chk("pin period", n, 16 * LFT_OSC_DIV);
      chk("pin oe", poe, 1);
      @(posedge clk);
      pd <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("pd level", {poe, po}, 3);
      cmd(8'h18);
      @(posedge clk);
      en <= 1'b1;
      #1;
      chk("pd off", poe, 0);
      repeat (40) @(posedge clk);
      #1;
      chk("pd in", poe, 0);
      @(posedge clk);
      pd <= 1'b0;
      en <= 1'b0;
      $display("t_pin done");
   endtask
   // output enable asked for too: an external source must still leave the pin alone
   task automatic t_ext(input logic f, input int e, input logic [1:0] mx, input int rr);
      int n;
      int r;
      logic [2:0] m;
      @(posedge clk);
      en <= 1'b1;
      pd <= f;
      cmd({6'h00, mx});
      cmd({5'h03, f, 2'h3});
      @(posedge clk);
      #1;
      chk("ext oe", poe, 0);
      gap(1'b0, n);
      gap(1'b0, n);
      chk("frame period", n, e);
      rows(r, m);
      chk("rows", r, rr);
      chk("last row", m, rr - 1);
      cmd(8'h18);
      @(posedge clk);
      en <= 1'b0;
      pd <= 1'b0;
      $display("t_ext done");
   endtask
   task automatic t_rst;
      cmd(8'h1a);
      @(posedge clk);
      #1;
      chk("oe set", poe, 1);
      @(posedge clk);
      rst <= 1'b1;
      #1;
      chk("rst oe mid", poe, 0);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("rst cfg 2", {fd, q, nbp, bias, external_freq_range, clock_output_enable, src},
         {5'h0e, 7'h18, 4'h8, 5'h00});
      chk("rst oe after", poe, 0);
      $display("t_rst done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      #1;
      chk("rst oe", poe, 0);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("rst cfg", {fd, q, nbp, bias, external_freq_range, clock_output_enable, src}, {5'h0e, 7'h18, 4'h8, 5'h00});
      t_fd();
      t_mb();
      t_pin();
      t_ext(1'b0, 384, 2'h0, 8);
      t_ext(1'b1, 6144, 2'h3, 4);
      t_rst();
      complete_run();
   end
   // the run needs under half of this span
   initial begin
      #720000;
      num_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
